/* usds_pkg.sv */
/*
 * Package for the serial status, data buffer and baud select block.
 * Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
 */
package usds_pkg;
	// Register byte offsets
	localparam logic [7:0] ADDR_DATA_BUFFER = 8'h18;
	localparam logic [7:0] ADDR_STATUS_ONE  = 8'h1c;
	localparam logic [7:0] ADDR_STATUS_TWO  = 8'h20;
	localparam logic [7:0] ADDR_BAUD_SELECT = 8'h24;
	localparam logic [7:0] ADDR_CONTROL     = 8'h28;
	localparam logic [7:0] ADDR_FINE_PRESC  = 8'h2c;
	// Status one bit positions
	localparam int ST1_TX_EMPTY = 7;
	localparam int ST1_TX_DONE  = 6;
	localparam int ST1_RX_FULL  = 5;
	localparam int ST1_IDLE     = 4;
	localparam int ST1_OVERRUN  = 3;
	localparam int ST1_NOISE    = 2;
	localparam int ST1_FRAMING  = 1;
	localparam int ST1_PARITY   = 0;
	// Status two bit positions
	localparam int ST2_BREAK    = 1;
	localparam int ST2_RX_PROG  = 0;
	// Baud select fields
	localparam int BAUD_LIN     = 6;
	localparam int BAUD_PSC_LSB = 4;
	localparam int BAUD_DIV_LSB = 0;
	// Control register bits: irq enables then nine-bit mode
	localparam int CTL_TC_IE    = 0;
	localparam int CTL_RX_IE    = 1;
	localparam int CTL_IDLE_IE  = 2;
	localparam int CTL_OR_IE    = 3;
	localparam int CTL_NE_IE    = 4;
	localparam int CTL_FE_IE    = 5;
	localparam int CTL_PE_IE    = 6;
	localparam int CTL_NINE     = 7;
	// Reset values
	localparam logic [7:0] BAUD_RESET = 8'h00;
	localparam logic [7:0] CTL_RESET  = 8'h00;
	localparam logic [7:0] FINE_RESET = 8'h00;
	// Rate scaling
	localparam int OVERSAMPLE   = 64;
	localparam int FRAC_STEPS   = 32;
	localparam int BREAK_LEN_LIN8 = 11;
	localparam int BREAK_LEN_LIN9 = 12;
	localparam int BREAK_LEN_STD8 = 10;
	localparam int BREAK_LEN_STD9 = 11;
	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		TX_IDLE  = 3'h1,
		TX_QUEUE = 3'h2,
		TX_SHIFT = 3'h4
	} usds_tx_type;
endpackage

/* usds_core.sv */
/*
 * Status flags, shared data buffer and baud rate select for an
 * asynchronous serial port with LIN break detection, as an AXI4-Lite slave.
 * Assumes the receive and transmit shift engines live outside and report
 * events as single-cycle pulses on aclk; rx_pin comes from a pad.
 */
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// R01 - Transmit done when empty and idle
// R02 - Queueing clears transmit done flag
// R03 - Completed character sets receive full
// R04 - Status-one then data read clears full
// R05 - Idle after ones, same clearing sequence
// R06 - Idle armed only after new character
// R07 - Overrun keeps old data, drops new
// R08 - Overrun clears only if seen first
// R09 - Noise flag set, cleared by sequence
// R10 - Zero stop bit sets framing error
// R11 - Parity failure sets parity flag
// R12 - Reset clears receive flags and break
// R13 - Break sets break, framing, full flags
// R14 - Break clears via status-two sequence
// R15 - Zero at first slot sets progress
// R16 - False start or idle clears progress
// R17 - One address, read rx, write tx
// R18 - Software avoids read-modify-write on buffer
// R19 - LIN mode lengthens break detection
// R20 - Prescale codes give 1,3,4,13
// R21 - Divisor field gives power of two
// R22 - One rate clocks receiver and transmitter
// R23 - Rate is bus over 64 products
// R24 - Record flags seen at status read
module usds_core
	import usds_pkg::*;
(
	// Clock, reset, enable
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        clk_en,
	// AXI4-Lite write
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Receive engine events
	input  wire logic        rx_pin,
	input  wire logic        rx_char_done,
	input  wire logic [8:0]  rx_char,
	input  wire logic        rx_noise,
	input  wire logic        rx_stop_zero,
	input  wire logic        rx_parity_bad,
	input  wire logic        rx_enable,
	input  wire logic        rx_slot_zero,
	input  wire logic        rx_false_start,
	// Transmit engine handshake
	input  wire logic        tx_busy,
	input  wire logic        tx_take,
	output logic             tx_load,
	output logic [7:0]       tx_data,
	// Derived controls and flags
	output logic             rate_tick,
	output logic             rx_ninth_bit,
	output logic             tx_complete_flag,
	output logic             tx_empty_flag,
	output logic             tx_irq,
	output logic             rx_irq,
	output logic             err_irq
);
	logic        rx_s1_r, rx_s2_r, rx_prev_r;
	logic        tx_empty_r, tx_done_r, tx_load_r;
	logic [7:0]  tx_buf_r;
	logic [7:0]  rx_buf_r;
	logic        ninth_r;
	logic        full_r, idle_r, over_r, noise_r, fram_r, par_r, brk_r, prog_r;
	logic        idle_arm_r, brk_arm_r;
	logic [7:0]  seen1_r;
	logic        seen_brk_r;
	logic [7:0]  baud_r, ctl_r, fine_r;
	logic [4:0]  ones_r, zeros_r;
	logic        aw_r, w_r, bv_r, rv_r;
	logic        aw_rdy_r, w_rdy_r, ar_rdy_r;
	logic [7:0]  awaddr_r;
	logic [31:0] wdata_r, rdata_r;
	logic [3:0]  wstrb_r;
	logic [1:0]  bresp_r, rresp_r;
	logic        wr_go, rd_go, rd_data, rd_st1, rd_st2, wr_data;
	logic [7:0]  st1, st2;
	logic [4:0]  idle_len, brk_len;
	logic        idle_evt, brk_evt, char_in;
	logic [4:0]  prescale_divisor;
	logic [7:0]  bd;
	logic [3:0]  pd;
	logic [15:0] rate_cnt_r, rate_div;
	logic [4:0]  frac_acc_r;
	logic        frac_carry, rate_tick_r;
	logic        irq_tx_r, irq_rx_r, irq_err_r;
	usds_tx_type tx_st_r;

	assign st1 = {tx_empty_r, tx_done_r, full_r, idle_r, over_r, noise_r, fram_r, par_r};
	assign st2 = {6'h00, brk_r, prog_r};

	// Pin synchroniser: second stage feeds all logic
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_s1_r <= 1'b1;
			rx_s2_r <= 1'b1;
			rx_prev_r <= 1'b1;
		end else if (clk_en) begin
			rx_s1_r <= rx_pin;
			rx_s2_r <= rx_s1_r;
			rx_prev_r <= rx_s2_r;
		end
	end

	// AXI write channel: address and data in either order
	assign wr_go = aw_r && w_r && !bv_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_r <= 1'b0;
			w_r <= 1'b0;
			bv_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0;
			wstrb_r <= 4'h0;
			bresp_r <= RESP_OKAY;
			aw_rdy_r <= 1'b1;
			w_rdy_r <= 1'b1;
		end else if (clk_en) begin
			if (s_axi_awvalid && !aw_r && !bv_r) begin
				aw_r <= 1'b1;
				aw_rdy_r <= 1'b0;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_r && !bv_r) begin
				w_r <= 1'b1;
				w_rdy_r <= 1'b0;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_r <= 1'b0;
				w_r <= 1'b0;
				bv_r <= 1'b1;
				if (awaddr_r == ADDR_DATA_BUFFER || awaddr_r == ADDR_BAUD_SELECT ||
				    awaddr_r == ADDR_CONTROL || awaddr_r == ADDR_FINE_PRESC)
					bresp_r <= RESP_OKAY;
				else
					bresp_r <= RESP_SLVERR;
			end else if (bv_r && s_axi_bready) begin
				bv_r <= 1'b0;
				aw_rdy_r <= 1'b1;
				w_rdy_r <= 1'b1;
			end
		end
	end
	assign s_axi_awready = aw_rdy_r;
	assign s_axi_wready  = w_rdy_r;
	assign s_axi_bvalid  = bv_r;
	assign s_axi_bresp   = bresp_r;
	assign wr_data = wr_go && wstrb_r[0] && awaddr_r == ADDR_DATA_BUFFER;

	// AXI read channel: one cycle to answer
	assign rd_go   = s_axi_arvalid && !rv_r && clk_en;
	assign rd_data = rd_go && s_axi_araddr == ADDR_DATA_BUFFER;
	assign rd_st1  = rd_go && s_axi_araddr == ADDR_STATUS_ONE;
	assign rd_st2  = rd_go && s_axi_araddr == ADDR_STATUS_TWO;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rv_r <= 1'b0;
			rdata_r <= 32'h0;
			rresp_r <= RESP_OKAY;
			ar_rdy_r <= 1'b1;
		end else if (clk_en) begin
			if (rd_go) begin
				rv_r <= 1'b1;
				ar_rdy_r <= 1'b0;
				rresp_r <= RESP_OKAY;
				// R17 shared buffer read
				if (s_axi_araddr == ADDR_DATA_BUFFER)
					rdata_r <= {24'h0, rx_buf_r};
				else if (s_axi_araddr == ADDR_STATUS_ONE)
					rdata_r <= {24'h0, st1};
				else if (s_axi_araddr == ADDR_STATUS_TWO)
					rdata_r <= {24'h0, st2};
				else if (s_axi_araddr == ADDR_BAUD_SELECT)
					rdata_r <= {24'h0, baud_r};
				else if (s_axi_araddr == ADDR_CONTROL)
					rdata_r <= {24'h0, ctl_r};
				else if (s_axi_araddr == ADDR_FINE_PRESC)
					rdata_r <= {24'h0, fine_r};
				else begin
					rdata_r <= 32'h0;
					rresp_r <= RESP_SLVERR;
				end
			end else if (rv_r && s_axi_rready) begin
				rv_r <= 1'b0;
				ar_rdy_r <= 1'b1;
			end
		end
	end
	assign s_axi_arready = ar_rdy_r;
	assign s_axi_rvalid  = rv_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	// Software configuration registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			baud_r <= BAUD_RESET;
			ctl_r <= CTL_RESET;
			fine_r <= FINE_RESET;
		end else if (clk_en && wr_go && wstrb_r[0]) begin
			// R19 R20 R21 mode and divisor fields
			if (awaddr_r == ADDR_BAUD_SELECT)
				baud_r <= {1'b0, wdata_r[6:0]};
			else if (awaddr_r == ADDR_CONTROL)
				ctl_r <= wdata_r[7:0];
			else if (awaddr_r == ADDR_FINE_PRESC)
				fine_r <= wdata_r[7:0];
		end
	end

	// R20 prescale divisor lookup
	always_comb begin
		case (baud_r[BAUD_PSC_LSB +: 2])
			2'h0: prescale_divisor = 5'd1;
			2'h1: prescale_divisor = 5'd3;
			2'h2: prescale_divisor = 5'd4;
			default: prescale_divisor = 5'd13;
		endcase
	end
	// R21 power of two divisor
	assign bd = 8'h01 << baud_r[BAUD_DIV_LSB +: 3];
	// Fine prescaler: bypass counts as one
	assign pd = (fine_r[7:5] == 3'h0) ? 4'h1 : {1'b0, fine_r[7:5]} + 4'h1;
	// R23 coarse product; 64 stays with the engines as oversampling
	assign rate_div = 16'(prescale_divisor) * 16'(bd) * 16'(pd);
	assign frac_carry = (5'(frac_acc_r + fine_r[4:0]) < frac_acc_r) && (fine_r[7:5] != 3'h0);

	// R22 R23 one rate tick for both engines, fraction stretches one count
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rate_cnt_r <= 16'h0;
			frac_acc_r <= 5'h0;
			rate_tick_r <= 1'b0;
		end else if (clk_en) begin
			rate_tick_r <= 1'b0;
			if (rate_cnt_r >= rate_div - 16'h1 + {15'h0, frac_carry}) begin
				rate_cnt_r <= 16'h0;
				rate_tick_r <= 1'b1;
				frac_acc_r <= 5'(frac_acc_r + fine_r[4:0]);
			end else begin
				rate_cnt_r <= rate_cnt_r + 16'h1;
			end
		end
	end
	assign rate_tick = rate_tick_r;

	// Line ones and zeros counted in bit times of 16 ticks
	assign idle_len = ctl_r[CTL_NINE] ? 5'(BREAK_LEN_STD9) : 5'(BREAK_LEN_STD8);
	// R19 break length depends on LIN mode
	assign brk_len = baud_r[BAUD_LIN] ?
		(ctl_r[CTL_NINE] ? 5'(BREAK_LEN_LIN9) : 5'(BREAK_LEN_LIN8)) : idle_len;
	logic [3:0] bit_ph_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ones_r <= 5'h0;
			zeros_r <= 5'h0;
			bit_ph_r <= 4'h0;
		end else if (clk_en) begin
			if (rx_s2_r != rx_prev_r) begin
				bit_ph_r <= 4'h0;
				ones_r <= 5'h0;
				zeros_r <= 5'h0;
			end else if (rate_tick_r) begin
				bit_ph_r <= bit_ph_r + 4'h1;
				if (bit_ph_r == 4'hf) begin
					if (rx_s2_r && ones_r != 5'h1f)
						ones_r <= ones_r + 5'h1;
					if (!rx_s2_r && zeros_r != 5'h1f)
						zeros_r <= zeros_r + 5'h1;
				end
			end
		end
	end
	assign idle_evt = rx_enable && rate_tick_r && bit_ph_r == 4'hf && rx_s2_r &&
		ones_r == idle_len - 5'h1;
	assign brk_evt = rx_enable && rate_tick_r && bit_ph_r == 4'hf && !rx_s2_r &&
		zeros_r == brk_len - 5'h1;
	assign char_in = rx_char_done && !brk_evt;

	// R24 remember flags seen by the status reads
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seen1_r <= 8'h00;
			seen_brk_r <= 1'b0;
		end else if (clk_en) begin
			if (rd_st1)
				seen1_r <= st1;
			else if (rd_data)
				seen1_r <= 8'h00;
			if (rd_st2)
				seen_brk_r <= brk_r;
			else if (rd_data)
				seen_brk_r <= 1'b0;
		end
	end

	// Receive flags: a set in the clearing cycle wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// R12 receive flags cleared
			full_r <= 1'b0;
			idle_r <= 1'b0;
			over_r <= 1'b0;
			noise_r <= 1'b0;
			fram_r <= 1'b0;
			par_r <= 1'b0;
			brk_r <= 1'b0;
			prog_r <= 1'b0;
			idle_arm_r <= 1'b0;
			brk_arm_r <= 1'b1;
		end else if (clk_en) begin
			// R04 R08 sequence clears recorded flags
			if (rd_data) begin
				if (seen1_r[ST1_RX_FULL]) full_r <= 1'b0;
				if (seen1_r[ST1_IDLE]) idle_r <= 1'b0;
				if (seen1_r[ST1_OVERRUN]) over_r <= 1'b0;
				if (seen1_r[ST1_NOISE]) noise_r <= 1'b0;
				if (seen1_r[ST1_FRAMING]) fram_r <= 1'b0;
				if (seen1_r[ST1_PARITY]) par_r <= 1'b0;
				// R14 break cleared via status two
				if (seen_brk_r) brk_r <= 1'b0;
			end
			if (!rx_enable)
				idle_arm_r <= 1'b0;
			else if (rd_data && seen1_r[ST1_IDLE])
				idle_arm_r <= 1'b0;
			// R03 R07 character lands or overruns
			if (char_in) begin
				if (full_r && !(rd_data && seen1_r[ST1_RX_FULL]))
					over_r <= 1'b1;
				else begin
					full_r <= 1'b1;
					idle_arm_r <= 1'b1;
				end
			end
			// R09 R10 R11 error flags
			if (char_in && rx_noise) noise_r <= 1'b1;
			if (char_in && rx_stop_zero) fram_r <= 1'b1;
			if (char_in && rx_parity_bad) par_r <= 1'b1;
			// R05 R06 idle only when armed
			if (idle_evt && idle_arm_r) begin
				idle_r <= 1'b1;
				idle_arm_r <= 1'b0;
			end
			// R13 break sets three flags
			if (brk_evt && brk_arm_r) begin
				brk_r <= 1'b1;
				fram_r <= 1'b1;
				full_r <= 1'b1;
				brk_arm_r <= 1'b0;
			end else if (rx_s2_r) begin
				brk_arm_r <= 1'b1;
			end
			// R15 R16 reception in progress
			if (rx_slot_zero)
				prog_r <= 1'b1;
			else if (rx_false_start || idle_evt || char_in)
				prog_r <= 1'b0;
		end
	end

	// Receive data buffer; reset leaves contents alone
	always_ff @(posedge aclk) begin
		if (clk_en) begin
			if (brk_evt && brk_arm_r) begin
				rx_buf_r <= 8'h00;
				// R13 ninth bit cleared on break in nine-bit mode only
				if (ctl_r[CTL_NINE]) ninth_r <= 1'b0;
			end else if (char_in && !full_r) begin
				// R07 older data kept on overrun
				rx_buf_r <= rx_char[7:0];
				ninth_r <= ctl_r[CTL_NINE] ? rx_char[8] : rx_char[7];
			end
		end
	end

	// Transmit side
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_st_r <= TX_IDLE;
			tx_empty_r <= 1'b1;
			tx_done_r <= 1'b1;
			tx_load_r <= 1'b0;
			tx_buf_r <= 8'h00;
		end else if (clk_en) begin
			tx_load_r <= 1'b0;
			// R17 shared buffer write
			if (wr_data) begin
				tx_buf_r <= wdata_r[7:0];
				tx_empty_r <= 1'b0;
			end
			case (tx_st_r)
				TX_IDLE: begin
					if (wr_data || tx_busy) begin
						tx_st_r <= TX_QUEUE;
						// R02 queueing clears done
						tx_done_r <= 1'b0;
					end
				end
				TX_QUEUE: begin
					if (!tx_empty_r && tx_take) begin
						tx_load_r <= 1'b1;
						tx_empty_r <= 1'b1;
						tx_st_r <= TX_SHIFT;
					end else if (tx_empty_r && !tx_busy) begin
						tx_st_r <= TX_IDLE;
						tx_done_r <= 1'b1;
					end
				end
				default: begin
					// Busy rises a cycle after the load pulse; wait it out
					// R01 done once empty and quiet
					if (tx_empty_r && !tx_busy && !wr_data && !tx_load_r) begin
						tx_st_r <= TX_IDLE;
						tx_done_r <= 1'b1;
					end else if (!tx_empty_r || wr_data) begin
						tx_st_r <= TX_QUEUE;
					end
				end
			endcase
		end
	end

	// Interrupt requests; break and progress never interrupt
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_tx_r <= 1'b0;
			irq_rx_r <= 1'b0;
			irq_err_r <= 1'b0;
		end else if (clk_en) begin
			irq_tx_r <= tx_done_r && ctl_r[CTL_TC_IE];
			irq_rx_r <= (full_r && ctl_r[CTL_RX_IE]) || (idle_r && ctl_r[CTL_IDLE_IE]);
			irq_err_r <= (over_r && ctl_r[CTL_OR_IE]) || (noise_r && ctl_r[CTL_NE_IE]) ||
				(fram_r && ctl_r[CTL_FE_IE]) || (par_r && ctl_r[CTL_PE_IE]);
		end
	end
	assign tx_irq = irq_tx_r;
	assign rx_irq = irq_rx_r;
	assign err_irq = irq_err_r;
	assign tx_load = tx_load_r;
	assign tx_data = tx_buf_r;
	assign rx_ninth_bit = ninth_r;
	assign tx_complete_flag = tx_done_r;
	assign tx_empty_flag = tx_empty_r;

	// R03 full follows a landed character
	AST_FULL_SET: assert property (@(posedge aclk) disable iff (!aresetn) // R03
		clk_en && char_in && !full_r |=> full_r)
		else $error("receive full not set");
	// R07 overrun keeps buffer
	AST_OVR_KEEP: assert property (@(posedge aclk) disable iff (!aresetn) // R07
		clk_en && char_in && full_r && !rd_data |=> over_r && $stable(rx_buf_r))
		else $error("overrun handling wrong");
	// R08 unseen overrun survives data read
	AST_OVR_HOLD: assert property (@(posedge aclk) disable iff (!aresetn) // R08
		clk_en && rd_data && over_r && !seen1_r[ST1_OVERRUN] |=> over_r)
		else $error("overrun cleared without status read");
	// R04 sequence clears full
	AST_FULL_CLR: assert property (@(posedge aclk) disable iff (!aresetn) // R04
		clk_en && rd_data && seen1_r[ST1_RX_FULL] && !char_in && !brk_evt |=> !full_r)
		else $error("receive full not cleared");
	// R13 break sets framing and full
	AST_BRK_SET: assert property (@(posedge aclk) disable iff (!aresetn) // R13
		clk_en && brk_evt && brk_arm_r |=> brk_r && fram_r && full_r)
		else $error("break flags missing");
	// R06 idle needs arming
	AST_IDLE_ARM: assert property (@(posedge aclk) disable iff (!aresetn) // R06
		$rose(idle_r) |-> $past(idle_arm_r))
		else $error("idle set without character");
	// R02 write clears done
	AST_TC_CLR: assert property (@(posedge aclk) disable iff (!aresetn) // R02
		clk_en && wr_data && tx_st_r == TX_IDLE |=> !tx_done_r)
		else $error("transmit done not cleared");
	// R15 slot zero sets progress
	AST_PROG_SET: assert property (@(posedge aclk) disable iff (!aresetn) // R15
		clk_en && rx_slot_zero |=> prog_r)
		else $error("progress flag not set");
endmodule // usds_core
`default_nettype wire

/* usds_far.sv */
/*
 * Far-side model: the receive engine events and the transmit engine.
 * Assumes one aclk domain; the bench calls its tasks right after an edge.
 */
`timescale 1ns/100ps
`default_nettype none
module usds_far (
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Transmit engine
	input  wire logic       tx_load,
	output logic            tx_busy,
	output logic            tx_take,
	// Receive engine
	output logic            rx_pin,
	output logic            rx_char_done,
	output logic [8:0]      rx_char,
	output logic            rx_noise,
	output logic            rx_stop_zero,
	output logic            rx_parity_bad,
	output logic            rx_enable,
	output logic            rx_slot_zero,
	output logic            rx_false_start
);
	int busy_cnt;

	initial begin
		rx_pin = 1'b1;
		rx_char_done = 1'b0;
		rx_char = 9'h000;
		{rx_noise, rx_stop_zero, rx_parity_bad} = 3'h0;
		rx_enable = 1'b1;
		rx_slot_zero = 1'b0;
		rx_false_start = 1'b0;
	end

	always @(posedge aclk) begin
		if (!aresetn)
			busy_cnt <= 0;
		else if (tx_load)
			busy_cnt <= 20;
		else if (busy_cnt > 0)
			busy_cnt <= busy_cnt - 1;
	end

	always_comb begin
		tx_busy = (busy_cnt != 0);
		tx_take = !tx_busy;
	end

	// One finished character with its qualifiers
	task chr(input logic [8:0] c, input logic [2:0] q);
		@(posedge aclk);
		// Start bit: the line edge restarts the block's idle count
		rx_pin <= 1'b0;
		repeat (16) @(posedge aclk);
		rx_pin <= 1'b1;
		rx_char <= c;
		{rx_noise, rx_stop_zero, rx_parity_bad} <= q;
		rx_char_done <= 1'b1;
		@(posedge aclk);
		rx_char_done <= 1'b0;
		{rx_noise, rx_stop_zero, rx_parity_bad} <= 3'h0;
		// Data is not held once the pulse is gone
		rx_char <= ~c;
	endtask

	task pls(input logic f);
		@(posedge aclk);
		rx_slot_zero <= !f;
		rx_false_start <= f;
		@(posedge aclk);
		rx_slot_zero <= 1'b0;
		rx_false_start <= 1'b0;
	endtask

	task low(input int n);
		@(posedge aclk);
		rx_pin <= 1'b0;
		repeat (n) @(posedge aclk);
		rx_pin <= 1'b1;
	endtask
endmodule // usds_far
`default_nettype wire

/* uart_status_data_baud_select_tb.sv */
/*
 * Self-checking bench: AXI4-Lite tasks and register sequences.
 * Assumes the far-side model drives the engine events.
 */
`timescale 1ns/100ps
`default_nettype none
module uart_status_data_baud_select_tb
	import usds_pkg::*;
;
	logic aclk, aresetn, ce, aw_v, w_v, ar_v, b_r, r_r;
	logic aw_rdy, w_rdy, b_v, ar_rdy, r_v;
	logic [7:0] aw_a, ar_a, tx_data;
	logic [31:0] w_d, r_d;
	logic [1:0] b_resp, r_resp, resp;
	logic rx_pin, rx_done, rx_nz, rx_sz, rx_pb, rx_en, rx_s0, rx_fs;
	logic [8:0] rx_char;
	logic tx_busy, tx_take, tx_load, tick, ninth, tc, te, tx_irq, rx_irq, err_irq;
	logic [3:0] w_s;
	int errors, tests_run, n, p;
	int prescale_divisor[4] = '{1, 3, 4, 13};

	always #20 aclk = ~aclk;

	usds_core usds_core_i (.aclk(aclk), .aresetn(aresetn), .clk_en(ce),
		.s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy),
		.s_axi_wdata(w_d), .s_axi_wstrb(w_s), .s_axi_wvalid(w_v),
		.s_axi_wready(w_rdy), .s_axi_bresp(b_resp), .s_axi_bvalid(b_v),
		.s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
		.s_axi_arready(ar_rdy), .s_axi_rdata(r_d), .s_axi_rresp(r_resp),
		.s_axi_rvalid(r_v), .s_axi_rready(r_r), .rx_pin(rx_pin),
		.rx_char_done(rx_done), .rx_char(rx_char), .rx_noise(rx_nz),
		.rx_stop_zero(rx_sz), .rx_parity_bad(rx_pb), .rx_enable(rx_en),
		.rx_slot_zero(rx_s0), .rx_false_start(rx_fs), .tx_busy(tx_busy),
		.tx_take(tx_take), .tx_load(tx_load), .tx_data(tx_data), .rate_tick(tick),
		.rx_ninth_bit(ninth), .tx_complete_flag(tc), .tx_empty_flag(te),
		.tx_irq(tx_irq), .rx_irq(rx_irq), .err_irq(err_irq));

	usds_far usds_far_i (.aclk(aclk), .aresetn(aresetn), .tx_load(tx_load),
		.tx_busy(tx_busy), .tx_take(tx_take), .rx_pin(rx_pin), .rx_char_done(rx_done),
		.rx_char(rx_char), .rx_noise(rx_nz), .rx_stop_zero(rx_sz),
		.rx_parity_bad(rx_pb), .rx_enable(rx_en), .rx_slot_zero(rx_s0),
		.rx_false_start(rx_fs));

	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask

	task test_done;
		if (errors == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// plain writes only, never read-modify-write on the buffer
	task wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] r);
		logic ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge aclk);
		aw_a <= a;
		w_d <= {24'h000000, v};
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_r <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (!ad && aw_rdy === 1'b1) begin
				ad = 1'b1;
				aw_v <= 1'b0;
			end
			if (!wd && w_rdy === 1'b1) begin
				wd = 1'b1;
				w_v <= 1'b0;
			end
		end
		while (b_v !== 1'b1) @(posedge aclk);
		r = b_resp;
		b_r <= 1'b0;
	endtask

	task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
		@(posedge aclk);
		ar_a <= a;
		ar_v <= 1'b1;
		r_r <= 1'b1;
		do @(posedge aclk); while (ar_rdy !== 1'b1);
		ar_v <= 1'b0;
		while (r_v !== 1'b1) @(posedge aclk);
		v = r_d;
		r = r_resp;
		r_r <= 1'b0;
	endtask

	// Read a register and compare the masked byte
	task rc(input string nm, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [31:0] v;
		rd(a, v, resp);
		chk(nm, v & {24'h000000, m}, {24'h000000, e});
	endtask

	task wtick;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (tick !== 1'b1 && n < 300);
	endtask

	task rate(input logic [7:0] b, input logic [7:0] f, input int e);
		wr(ADDR_FINE_PRESC, f, resp);
		wr(ADDR_BAUD_SELECT, b, resp);
		wtick;
		wtick;
		wtick;
		chk("rate period", n, e);
	endtask

	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{aw_v, w_v, ar_v, b_r, r_r} = 5'h00;
		ce = 1'b1;
		w_s = 4'hf;
		aw_a = 8'h00;
		ar_a = 8'h00;
		w_d = 32'h00000000;
		errors = 0;
		tests_run = 0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rc("status one", ADDR_STATUS_ONE, 8'hff, 8'hc0);
		rc("status two", ADDR_STATUS_TWO, 8'hff, 8'h00);
		rc("baud", ADDR_BAUD_SELECT, 8'hff, 8'h00);
		rc("unmapped", 8'h30, 8'hff, 8'h00);
		chk("unmapped rresp", resp, RESP_SLVERR);
		wr(8'h30, 8'h55, resp);
		chk("unmapped bresp", resp, RESP_SLVERR);
		for (int i = 0; i < 4; i++)
			rate(8'(i << BAUD_PSC_LSB) | 8'h03, 8'h00, prescale_divisor[i] * 8);
		for (int j = 0; j < 8; j++)
			rate(8'(j), 8'h00, 1 << j);
		rate(8'h00, 8'he0, 8);
		// Clock enable low freezes the rate counter mid-count
		ce <= 1'b0;
		p = 0;
		repeat (20) begin
			@(posedge aclk);
			if (tick === 1'b1)
				p++;
		end
		chk("frozen ticks", p, 0);
		ce <= 1'b1;
		wtick;
		chk("resumed count", n, 8);
		rate(8'h00, 8'h00, 1);
		usds_far_i.chr(9'h05a, 3'h0);
		repeat (300) @(posedge aclk);
		rc("idle set", ADDR_STATUS_ONE, 8'hff, 8'hf0);
		rc("data", ADDR_DATA_BUFFER, 8'hff, 8'h5a);
		rc("cleared", ADDR_STATUS_ONE, 8'hff, 8'hc0);
		usds_far_i.low(2);
		repeat (300) @(posedge aclk);
		rc("idle disarmed", ADDR_STATUS_ONE, 8'hff, 8'hc0);
		usds_far_i.chr(9'h011, 3'h0);
		usds_far_i.chr(9'h022, 3'h0);
		rc("overrun", ADDR_STATUS_ONE, 8'hef, 8'he8);
		rc("kept data", ADDR_DATA_BUFFER, 8'hff, 8'h11);
		rc("overrun clear", ADDR_STATUS_ONE, 8'hef, 8'hc0);
		usds_far_i.chr(9'h033, 3'h0);
		rc("full only", ADDR_STATUS_ONE, 8'hef, 8'he0);
		usds_far_i.chr(9'h044, 3'h0);
		rc("data late", ADDR_DATA_BUFFER, 8'hff, 8'h33);
		rc("overrun stays", ADDR_STATUS_ONE, 8'hef, 8'hc8);
		rc("data again", ADDR_DATA_BUFFER, 8'hff, 8'h33);
		rc("overrun gone", ADDR_STATUS_ONE, 8'hef, 8'hc0);
		wr(ADDR_CONTROL, 8'h52, resp);
		usds_far_i.chr(9'h0ff, 3'h7);
		rc("errors", ADDR_STATUS_ONE, 8'hef, 8'he7);
		chk("rx irq", rx_irq, 1'b1);
		chk("err irq", err_irq, 1'b1);
		chk("ninth copy", ninth, 1'b1);
		rc("data err", ADDR_DATA_BUFFER, 8'hff, 8'hff);
		rc("errors clear", ADDR_STATUS_ONE, 8'hef, 8'hc0);
		chk("rx irq off", rx_irq, 1'b0);
		chk("err irq off", err_irq, 1'b0);
		wr(ADDR_CONTROL, 8'h01, resp);
		@(posedge aclk);
		chk("tc irq idle", tx_irq, 1'b1);
		fork
			wr(ADDR_DATA_BUFFER, 8'ha5, resp);
			begin
				p = 0;
				do begin
					@(posedge aclk);
					p++;
				end while (tx_load !== 1'b1 && p < 50);
				chk("tx data", tx_data, 8'ha5);
			end
		join
		chk("tx bresp", resp, RESP_OKAY);
		repeat (3) @(posedge aclk);
		chk("tc busy", tc, 1'b0);
		chk("tc irq busy", tx_irq, 1'b0);
		repeat (30) @(posedge aclk);
		chk("tc done", tc, 1'b1);
		chk("tc irq done", tx_irq, 1'b1);
		chk("tx empty", te, 1'b1);
		rc("tx flags", ADDR_STATUS_ONE, 8'hc0, 8'hc0);
		wr(ADDR_CONTROL, 8'h00, resp);
		usds_far_i.pls(1'b0);
		rc("in progress", ADDR_STATUS_TWO, 8'h01, 8'h01);
		usds_far_i.pls(1'b1);
		rc("false start", ADDR_STATUS_TWO, 8'h01, 8'h00);
		wr(ADDR_BAUD_SELECT, 8'h40, resp);
		rc("lin mode", ADDR_BAUD_SELECT, 8'hff, 8'h40);
		usds_far_i.low(170);
		repeat (50) @(posedge aclk);
		rc("short low", ADDR_STATUS_TWO, 8'h02, 8'h00);
		usds_far_i.low(230);
		repeat (50) @(posedge aclk);
		rc("break", ADDR_STATUS_TWO, 8'h02, 8'h02);
		rc("break s1", ADDR_STATUS_ONE, 8'h22, 8'h22);
		rc("break data", ADDR_DATA_BUFFER, 8'hff, 8'h00);
		rc("break clear", ADDR_STATUS_TWO, 8'h02, 8'h00);
		w_s <= 4'h0;
		wr(ADDR_BAUD_SELECT, 8'h7f, resp);
		w_s <= 4'hf;
		rc("strobe off", ADDR_BAUD_SELECT, 8'hff, 8'h40);
		test_done;
	end

	initial begin
		repeat (20000) @(posedge aclk);
		errors++;
		test_done;
	end
endmodule // uart_status_data_baud_select_tb
`default_nettype wire
